// file: bench/one_wire_host_auth_protocol_bench.sv
// self-checking bench of the protocol engine with shortened intervals
// assumes the host model drives the link side; executor pulses come from here
module one_wire_host_auth_protocol_bench
	import owa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int IO_T = 50;
	localparam int WD   = 2000;
	localparam int WK   = 8;
	localparam int PR   = 20;

	logic       core_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       exec_reject = 1'b0;
	logic       exec_done = 1'b0;
	logic [7:0] exec_result = 8'h00;
	logic       line, tok_start, bit_valid, bit_val, tx_ready, tx_valid;
	logic       cmd_valid, cmd_go, busy, asleep;
	logic [7:0] tx_byte, cmd_byte;
	logic [7:0] cmd_q[$];
	logic [7:0] pkt[$] = '{8'h08, 8'h01, 8'h00, 8'h00};
	int         num_errors = 0;
	int         checks = 0;
	int         cyc = 0;
	int         go_cnt = 0;

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cmd_valid === 1'b1) cmd_q.push_back(cmd_byte);
		if (cmd_go === 1'b1) go_cnt <= go_cnt + 1;
	end

	owa_host_model i_host (.core_clk_i(core_clk), .line_o(line), .tok_start_o(tok_start),
		.bit_valid_o(bit_valid), .bit_val_o(bit_val), .tx_ready_o(tx_ready),
		.tx_valid_i(tx_valid), .tx_byte_i(tx_byte));

	owa_engine #(.IO_TIMEOUT_CYC(IO_T), .WDOG_CYC(WD), .WAKE_CYC(WK), .PARSE_CYC(PR),
		.FIFO_DEPTH(32)) i_dut (.core_clk_i(core_clk), .nrst_i(nrst), .line_i(line),
		.tok_start_i(tok_start), .bit_valid_i(bit_valid), .bit_val_i(bit_val),
		.exec_reject_i(exec_reject), .exec_done_i(exec_done), .exec_result_i(exec_result),
		.tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
		.cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte), .cmd_go_o(cmd_go),
		.busy_o(busy), .asleep_o(asleep));

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp, input string what);
		check_byte({7'h00, got}, {7'h00, exp}, what);
	endtask

	task automatic check_range(input int v, input int lo, input int hi, input string what);
		checks++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("MISMATCH t=%0t %s %0d not in %0d..%0d", $time, what, v, lo, hi);
		end
	endtask

	task automatic pass_cycles(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic expect_resp(input logic [7:0] p[$]);
		logic [7:0]  exp[$];
		logic [15:0] c;
		int          n;
		exp = p;
		exp.push_front(8'(p.size() + 3));
		c = i_host.crc16(exp);
		exp.push_back(c[7:0]);
		exp.push_back(c[15:8]);
		n = 0;
		while (i_host.rx_q.size() < exp.size() && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		pass_cycles(4);
		check_range(i_host.rx_q.size(), exp.size(), exp.size(), "response length");
		foreach (exp[k]) if (k < i_host.rx_q.size())
			check_byte(i_host.rx_q[k], exp[k], "response byte");
		i_host.rx_q.delete();
	endtask

	task automatic expect_none();
		pass_cycles(40);
		check_range(i_host.rx_q.size(), 0, 0, "unexpected response");
		i_host.rx_q.delete();
	endtask

	task automatic wait_asleep();
		int n;
		n = 0;
		while (asleep !== 1'b1 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	task automatic new_session();
		i_host.send_byte(FLAG_SLEEP);
		pass_cycles(4);
		check_flag(asleep, 1'b1, "asleep after sleep flag");
		cmd_q.delete();
		i_host.wake();
		check_flag(asleep, 1'b0, "awake after wake");
	endtask

	task automatic sc_wake_status();
		new_session();
		i_host.send_byte(8'hA5);
		expect_none();
		i_host.send_byte(FLAG_TX);
		expect_resp('{STAT_WAKE});
	endtask

	task automatic sc_good_cmd();
		int g0;
		new_session();
		g0 = go_cnt;
		i_host.send_block(pkt, 1'b0);
		pass_cycles(3);
		check_range(go_cnt - g0, 1, 1, "start pulses");
		check_flag(busy, 1'b1, "busy after block");
		check_range(cmd_q.size(), 4, 4, "packet length");
		foreach (pkt[k]) if (k < cmd_q.size()) check_byte(cmd_q[k], pkt[k], "packet");
		pass_cycles(PR + 5);
		i_host.send_byte(FLAG_TX);
		expect_none();
		pass_cycles(IO_T * 2);
		check_flag(asleep, 1'b0, "no timeout while executing");
		exec_result = 8'h3C;
		exec_done = 1'b1;
		pass_cycles(1);
		exec_done = 1'b0;
		pass_cycles(3);
		check_flag(busy, 1'b0, "idle after execution");
		i_host.send_byte(FLAG_TX);
		expect_resp('{8'h3C});
		i_host.slow = 1'b1;
		i_host.send_byte(FLAG_TX);
		expect_resp('{8'h3C});
		i_host.slow = 1'b0;
	endtask

	task automatic sc_bad_crc();
		int g0;
		new_session();
		g0 = go_cnt;
		i_host.send_block(pkt, 1'b1);
		pass_cycles(PR + 5);
		check_range(go_cnt - g0, 0, 0, "start on bad block");
		i_host.send_byte(FLAG_TX);
		expect_resp('{STAT_COMM_ERR});
	endtask

	task automatic sc_reject();
		new_session();
		i_host.send_block(pkt, 1'b0);
		pass_cycles(2);
		exec_reject = 1'b1;
		pass_cycles(1);
		exec_reject = 1'b0;
		pass_cycles(PR + 5);
		i_host.send_byte(FLAG_TX);
		expect_resp('{STAT_EXEC_ERR});
	endtask

	// no error poll: the host waits parse plus execution, then reads once
	task automatic sc_short_cmd();
		new_session();
		i_host.send_block(pkt, 1'b0);
		pass_cycles(PR + 5);
		exec_result = 8'h00;
		exec_done = 1'b1;
		pass_cycles(1);
		exec_done = 1'b0;
		pass_cycles(2);
		i_host.send_byte(FLAG_TX);
		expect_resp('{8'h00});
	endtask

	task automatic sc_timeouts();
		int t0;
		new_session();
		i_host.send_byte(FLAG_SLEEP);
		pass_cycles(2);
		t0 = cyc;
		i_host.wake();
		wait_asleep();
		check_range(cyc - t0, IO_T, IO_T + WK + 12, "sleep without first token");
		pass_cycles(IO_T * 2);
		i_host.wake();
		i_host.send_byte(FLAG_CMD);
		i_host.send_bits(8'h07, 5);
		i_host.stall_token();
		t0 = cyc;
		wait_asleep();
		check_range(cyc - t0, IO_T - 5, IO_T + 5, "sleep on stalled token");
		pass_cycles(IO_T);
		i_host.wake();
		i_host.send_byte(FLAG_TX);
		expect_resp('{STAT_WAKE});
		i_host.send_byte(FLAG_SLEEP);
		pass_cycles(4);
		check_flag(asleep, 1'b1, "asleep after resync");
	endtask

	task automatic sc_watchdog();
		int t0;
		int k;
		t0 = cyc;
		i_host.wake();
		k = 0;
		while (asleep !== 1'b1 && k < 120) begin
			i_host.send_byte(8'h00);
			k++;
		end
		check_range(cyc - t0, WD, WD + 40, "watchdog sleep");
	endtask

	task automatic complete_run();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge core_clk);
		nrst = 1'b1;
		sc_wake_status();
		sc_good_cmd();
		sc_bad_crc();
		sc_reject();
		sc_short_cmd();
		sc_timeouts();
		sc_watchdog();
		complete_run();
	end

	// the sequence needs about 4000 cycles; five times that means a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("MISMATCH t=%0t run did not finish", $time);
		complete_run();
	end
endmodule // one_wire_host_auth_protocol_bench

// file: bench/owa_host_model.sv
// system-side model: wakes the engine, sends flags and blocks bit by bit, takes response bytes
// assumes the engine samples its inputs on the rising edge of core_clk_i
module owa_host_model
	import owa_pkg::*;
(
	input  wire logic       core_clk_i,
	output logic            line_o,
	output logic            tok_start_o,
	output logic            bit_valid_o,
	output logic            bit_val_o,
	output logic            tx_ready_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_byte_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       slow = 1'b0;
	logic [7:0] rx_q[$];

	initial begin
		line_o = 1'b1;
		tok_start_o = 1'b0;
		bit_valid_o = 1'b0;
		bit_val_o = 1'b0;
	end

	// when slow, ready drops every other cycle so the buffer must hold bytes back
	always @(negedge core_clk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
	always @(posedge core_clk_i) if (tx_valid_i && tx_ready_o) rx_q.push_back(tx_byte_i);

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] r;
		logic        fb;
		r = 16'h0000;
		foreach (q[k]) for (int i = 0; i < 8; i++) begin
			fb = q[k][i] ^ r[15];
			r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	task automatic wake();
		@(negedge core_clk_i) line_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
		line_o = 1'b1;
		repeat (16) @(negedge core_clk_i);
	endtask

	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk_i) tok_start_o = 1'b1;
			@(negedge core_clk_i) tok_start_o = 1'b0;
			bit_valid_o = 1'b1;
			bit_val_o = b[i];
			@(negedge core_clk_i) bit_valid_o = 1'b0;
			bit_val_o = ~b[i];
		end
	endtask

	task automatic send_byte(input logic [7:0] b);
		send_bits(b, 8);
	endtask

	// a token that starts but never delivers its bit
	task automatic stall_token();
		@(negedge core_clk_i) tok_start_o = 1'b1;
		@(negedge core_clk_i) tok_start_o = 1'b0;
	endtask

	task automatic send_block(input logic [7:0] pkt[$], input logic bad);
		logic [7:0]  blk[$];
		logic [15:0] c;
		blk = pkt;
		blk.push_front(8'(pkt.size() + 3));
		c = crc16(blk) ^ {bad, 15'h0000};
		blk.push_back(c[7:0]);
		blk.push_back(c[15:8]);
		send_byte(FLAG_CMD);
		foreach (blk[k]) send_byte(blk[k]);
	endtask
endmodule // owa_host_model

// file: logic/owa_engine.sv
// command/response engine of the single-wire authentication device
// assumes a bit front end on core_clk_i that reports token starts and legal bits;
// an illegal token shows only as a start; the raw line level arrives unsynchronised for wake detection
module owa_engine
	import owa_pkg::*;
#(
	parameter int unsigned IO_TIMEOUT_CYC = IO_TIMEOUT_CYC_DEF,
	parameter int unsigned WDOG_CYC       = WDOG_CYC_DEF,
	parameter int unsigned WAKE_CYC       = WAKE_CYC_DEF,
	parameter int unsigned PARSE_CYC      = PARSE_DELAY_CYC,
	parameter int unsigned FIFO_DEPTH     = FIFO_DEPTH_DEF
) (
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       line_i,
	input  wire logic       tok_start_i,
	input  wire logic       bit_valid_i,
	input  wire logic       bit_val_i,
	input  wire logic       exec_reject_i,
	input  wire logic       exec_done_i,
	input  wire logic [7:0] exec_result_i,
	input  wire logic       tx_ready_i,
	output logic            tx_valid_o,
	output logic [7:0]      tx_byte_o,
	output logic            cmd_valid_o,
	output logic [7:0]      cmd_byte_o,
	output logic            cmd_go_o,
	output logic            busy_o,
	output logic            asleep_o
);
	owa_state_e  state_ff;
	owa_resp_e   resp_ff;
	logic        line_meta_ff;
	logic        line_sync_ff;
	logic [7:0]  shreg_ff;
	logic [2:0]  bitcnt_ff;
	logic        first_tok_ff;
	logic        tok_open_ff;
	logic [5:0]  idx_ff;
	logic [5:0]  len_ff;
	logic [15:0] crc_ff;
	logic [7:0]  crc_lo_ff;
	logic        comm_err_ff;
	logic [7:0]  result_ff;
	logic [1:0]  tx_idx_ff;
	logic        listen;
	logic        byte_done;
	logic [7:0]  rx_byte;
	logic        blk_end;
	logic        crc_ok;
	logic        flag_sleep;
	logic        io_run;
	logic        io_exp;
	logic        wdog_exp;
	logic        wake_exp;
	logic        parse_exp;
	logic        go_sleep;
	logic        awake;
	logic [7:0]  stat_byte;
	logic [15:0] tx_crc;
	logic        push;

	owa_stream_if #(.W(8)) txq ();

	// the first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			line_meta_ff <= 1'b1;
			line_sync_ff <= 1'b1;
		end else begin
			line_meta_ff <= line_i;
			line_sync_ff <= line_meta_ff;
		end
	end

	assign awake     = (state_ff != ST_SLEEP);
	assign listen    = (state_ff == ST_IDLE) || (state_ff == ST_RX_BLK);
	assign byte_done = listen && bit_valid_i && (bitcnt_ff == 3'h7);
	assign rx_byte   = {bit_val_i, shreg_ff[7:1]};
	assign flag_sleep = (state_ff == ST_IDLE) && byte_done && (rx_byte == FLAG_SLEEP);
	assign go_sleep  = awake && (wdog_exp || io_exp || flag_sleep);

	// armed before the first token, inside any token and across a command block;
	// quiet while parsing, executing or answering
	assign io_run = listen && (!first_tok_ff || tok_open_ff ||
		bitcnt_ff != 3'h0 || state_ff == ST_RX_BLK);

	owa_timer #(.LIMIT(IO_TIMEOUT_CYC)) u_io_tmr (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.run_i      (io_run),
		.clr_i      (bit_valid_i),
		.expired_o  (io_exp)
	);

	owa_timer #(.LIMIT(WDOG_CYC)) u_wdog_tmr (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.run_i      (awake),
		.clr_i      (1'b0),
		.expired_o  (wdog_exp)
	);

	owa_timer #(.LIMIT(WAKE_CYC)) u_wake_tmr (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.run_i      (state_ff == ST_WAKE_DLY),
		.clr_i      (1'b0),
		.expired_o  (wake_exp)
	);

	// one short: leaving parse adds the last cycle, so parse never outlasts PARSE_CYC
	owa_timer #(.LIMIT(PARSE_CYC - 1)) u_parse_tmr (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.run_i      (state_ff == ST_PARSE),
		.clr_i      (1'b0),
		.expired_o  (parse_exp)
	);

	// bit assembly; a partial byte is dropped when the engine stops listening
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !listen) begin
			shreg_ff  <= 8'h00;
			bitcnt_ff <= 3'h0;
		end else if (bit_valid_i) begin
			shreg_ff  <= rx_byte;
			bitcnt_ff <= bitcnt_ff + 3'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || state_ff == ST_WAKE_DLY)
			first_tok_ff <= 1'b0;
		else if (listen && (bit_valid_i || tok_start_i))
			first_tok_ff <= 1'b1;
	end

	// an illegal token starts but never yields a bit, so the timeout runs out;
	// a token starting on the edge of the previous bit keeps the flag set
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !listen)
			tok_open_ff <= 1'b0;
		else if (tok_start_i)
			tok_open_ff <= 1'b1;
		else if (bit_valid_i)
			tok_open_ff <= 1'b0;
	end

	// command block framing and check
	assign blk_end = (state_ff == ST_RX_BLK) && byte_done && (idx_ff == len_ff - 6'h1);
	assign crc_ok  = !comm_err_ff && ({rx_byte, crc_lo_ff} == crc_ff);

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || state_ff != ST_RX_BLK) begin
			idx_ff      <= 6'h00;
			len_ff      <= BLK_MIN;
			crc_ff      <= CRC_INIT;
			crc_lo_ff   <= 8'h00;
			comm_err_ff <= 1'b0;
		end else if (byte_done) begin
			idx_ff <= idx_ff + 6'h1;
			if (idx_ff == 6'h00) begin
				// out-of-range counts are clamped so the frame still ends
				if (rx_byte < 8'(BLK_MIN)) begin
					len_ff      <= BLK_MIN;
					comm_err_ff <= 1'b1;
				end else if (rx_byte > 8'(BLK_MAX)) begin
					len_ff      <= BLK_MAX;
					comm_err_ff <= 1'b1;
				end else begin
					len_ff <= rx_byte[5:0];
				end
				crc_ff <= crc16_byte(CRC_INIT, rx_byte);
			end else if (idx_ff < len_ff - 6'h2) begin
				crc_ff <= crc16_byte(crc_ff, rx_byte);
			end else if (idx_ff == len_ff - 6'h2) begin
				crc_lo_ff <= rx_byte;
			end
		end
	end

	// packet bytes stream to the executor as they arrive; it acts only on go
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || go_sleep) begin
			cmd_valid_o <= 1'b0;
			cmd_byte_o  <= 8'h00;
			cmd_go_o    <= 1'b0;
		end else begin
			cmd_valid_o <= (state_ff == ST_RX_BLK) && byte_done &&
				idx_ff != 6'h00 && idx_ff < len_ff - 6'h2;
			cmd_byte_o  <= rx_byte;
			cmd_go_o    <= blk_end && crc_ok;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || go_sleep) begin
			state_ff <= ST_SLEEP;
		end else begin
			unique case (state_ff)
				ST_SLEEP:    if (!line_sync_ff) state_ff <= ST_WAKE_DLY;
				ST_WAKE_DLY: if (wake_exp) state_ff <= ST_IDLE;
				ST_IDLE: begin
					if (byte_done && rx_byte == FLAG_CMD)
						state_ff <= ST_RX_BLK;
					else if (byte_done && rx_byte == FLAG_TX && resp_ff != RESP_NONE)
						state_ff <= ST_TX;
				end
				ST_RX_BLK:   if (blk_end) state_ff <= ST_PARSE;
				ST_PARSE: begin
					if (parse_exp)
						state_ff <= (resp_ff == RESP_NONE) ? ST_EXEC : ST_IDLE;
				end
				ST_EXEC:     if (exec_done_i || exec_reject_i) state_ff <= ST_IDLE;
				ST_TX:       if (push && tx_idx_ff == 2'h3) state_ff <= ST_IDLE;
			endcase
		end
	end

	// what the next transmit flag reports; kept for repeated reads
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || go_sleep) begin
			resp_ff   <= RESP_NONE;
			result_ff <= 8'h00;
		end else if (state_ff == ST_SLEEP && !line_sync_ff) begin
			resp_ff <= RESP_WAKE;
		end else if (blk_end) begin
			resp_ff <= crc_ok ? RESP_NONE : RESP_COMM;
		end else if ((state_ff == ST_PARSE || state_ff == ST_EXEC) &&
				exec_reject_i && resp_ff == RESP_NONE) begin
			resp_ff <= RESP_EXEC;
		end else if (state_ff == ST_EXEC && exec_done_i) begin
			resp_ff   <= RESP_OK;
			result_ff <= exec_result_i;
		end
	end

	always_comb begin
		unique case (resp_ff)
			RESP_WAKE: stat_byte = STAT_WAKE;
			RESP_EXEC: stat_byte = STAT_EXEC_ERR;
			RESP_COMM: stat_byte = STAT_COMM_ERR;
			RESP_OK:   stat_byte = result_ff;
			default:   stat_byte = 8'h00;
		endcase
	end

	assign tx_crc = crc16_byte(crc16_byte(CRC_INIT, STAT_BLK_LEN), stat_byte);
	assign push   = (state_ff == ST_TX) && txq.ready;

	// whole block: count, status, crc low, crc high
	always_comb begin
		unique case (tx_idx_ff)
			2'h0: txq.data = STAT_BLK_LEN;
			2'h1: txq.data = stat_byte;
			2'h2: txq.data = tx_crc[7:0];
			2'h3: txq.data = tx_crc[15:8];
		endcase
	end
	assign txq.valid = (state_ff == ST_TX);

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || state_ff != ST_TX)
			tx_idx_ff <= 2'h0;
		else if (push)
			tx_idx_ff <= tx_idx_ff + 2'h1;
	end

	owa_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.flush_i    (go_sleep),
		.wr         (txq),
		.rd_valid_o (tx_valid_o),
		.rd_data_o  (tx_byte_o),
		.rd_ready_i (tx_ready_i)
	);

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			busy_o   <= 1'b0;
			asleep_o <= 1'b1;
		end else begin
			busy_o   <= !go_sleep && (state_ff == ST_PARSE || state_ff == ST_EXEC ||
				(state_ff == ST_RX_BLK && blk_end));
			asleep_o <= go_sleep || (state_ff == ST_SLEEP && line_sync_ff);
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_tx_flag;
		state_ff == ST_IDLE && byte_done && rx_byte == FLAG_TX && resp_ff != RESP_NONE;
	endsequence
	sequence s_block;
		push && tx_idx_ff == 2'h0 ##1 push[*3];
	endsequence

	chk_wake_status: assert property (push && tx_idx_ff == 2'h1 &&
		resp_ff == RESP_WAKE |-> txq.data == STAT_WAKE)
		else $error("wake status not 0x11");
	chk_exec_code: assert property (push && tx_idx_ff == 2'h1 &&
		resp_ff == RESP_EXEC |-> txq.data == STAT_EXEC_ERR)
		else $error("exec error not 0x0F");
	chk_crc_reject: assert property (blk_end && !crc_ok
		|=> !cmd_go_o && resp_ff == RESP_COMM) else $error("bad block went on");
	chk_reread_again: assert property (s_tx_flag |=> state_ff == ST_TX)
		else $error("transmit flag not answered");
	chk_block_four: assert property (s_block |=> state_ff == ST_IDLE && !push)
		else $error("status block not four bytes");
	chk_busy_silent: assert property ((state_ff == ST_PARSE || state_ff == ST_EXEC)
		&& !go_sleep |=> state_ff != ST_TX) else $error("answered while busy");
	chk_sleep_flag: assert property (flag_sleep |=> state_ff == ST_SLEEP ##1 asleep_o)
		else $error("sleep flag not obeyed");
	chk_io_expiry: assert property (io_exp |=> state_ff == ST_SLEEP)
		else $error("io timeout did not sleep");
	chk_exec_no_tmo: assert property (state_ff == ST_EXEC |-> !io_run && !io_exp)
		else $error("io timeout live while busy");
	chk_wdog_sleep: assert property (wdog_exp && awake |=> state_ff == ST_SLEEP)
		else $error("watchdog did not sleep");
	chk_crc_first: assert property (state_ff == ST_RX_BLK && byte_done &&
		idx_ff == 6'h00 |=> crc_ff == crc16_byte(CRC_INIT, $past(rx_byte)))
		else $error("crc seed wrong");
endmodule // owa_engine

// file: logic/owa_fifo.sv
// byte FIFO with registered read data and a flush
// assumes the reader holds ready low to stall; the write side sees ready drop when full
module owa_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic          core_clk_i,
	input  wire logic          nrst_i,
	input  wire logic          flush_i,
	owa_stream_if.snk          wr,
	output logic               rd_valid_o,
	output logic [W-1:0]       rd_data_o,
	input  wire logic          rd_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wptr_ff;
	logic [AW:0]  rptr_ff;
	logic         empty;
	logic         full;
	logic         pop;

	assign empty    = (wptr_ff == rptr_ff);
	assign full     = (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]) && (wptr_ff[AW] != rptr_ff[AW]);
	assign wr.ready = !full;
	assign pop      = !empty && (!rd_valid_o || rd_ready_i);

	always_ff @(posedge core_clk_i) begin
		if (wr.valid && !full)
			mem[wptr_ff[AW-1:0]] <= wr.data;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || flush_i)
			wptr_ff <= '0;
		else if (wr.valid && !full)
			wptr_ff <= wptr_ff + (AW + 1)'(1);
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || flush_i)
			rptr_ff <= '0;
		else if (pop)
			rptr_ff <= rptr_ff + (AW + 1)'(1);
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || flush_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
		end else if (pop) begin
			rd_valid_o <= 1'b1;
			rd_data_o  <= mem[rptr_ff[AW-1:0]];
		end else if (rd_ready_i) begin
			rd_valid_o <= 1'b0;
		end
	end
endmodule // owa_fifo

// file: logic/owa_timer.sv
// interval counter: raises a one-cycle expiry pulse after LIMIT cycles of run
// assumes run and clr come from logic on the same clock
module owa_timer #(
	parameter int unsigned LIMIT = 16
) (
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	input  wire logic run_i,
	input  wire logic clr_i,
	output logic      expired_o
);
	localparam int unsigned CW = $clog2(LIMIT + 1);

	logic [CW-1:0] cnt_ff;

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || clr_i || !run_i)
			cnt_ff <= '0;
		else if (cnt_ff != CW'(LIMIT))
			cnt_ff <= cnt_ff + CW'(1);
	end

	// fires once; the count parks at LIMIT until cleared
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i)
			expired_o <= 1'b0;
		else
			expired_o <= run_i && !clr_i && (cnt_ff == CW'(LIMIT - 1));
	end
endmodule // owa_timer

// file: shared/owa_pkg.sv
// shared constants, types and the block checksum helper of the single-wire protocol engine
// assumes one 125 MHz core clock; bit-level token timing is decoded outside this block
package owa_pkg;

	localparam logic [7:0]  FLAG_CMD      = 8'h66;
	localparam logic [7:0]  FLAG_TX       = 8'h99;
	localparam logic [7:0]  FLAG_SLEEP    = 8'hCC;
	localparam logic [7:0]  STAT_WAKE     = 8'h11;
	localparam logic [7:0]  STAT_EXEC_ERR = 8'h0F;
	localparam logic [7:0]  STAT_COMM_ERR = 8'hFF;
	localparam logic [7:0]  STAT_BLK_LEN  = 8'h04;
	localparam logic [5:0]  BLK_MIN       = 6'h04;
	localparam logic [5:0]  BLK_MAX       = 6'h27;
	localparam logic [15:0] CRC_POLY      = 16'h8005;
	localparam logic [15:0] CRC_INIT      = 16'h0000;

	localparam int unsigned CLK_MHZ           = 125;
	localparam int unsigned PARSE_DELAY_US    = 100;
	// longest time: exact product, 12500 cycles
	localparam int unsigned PARSE_DELAY_CYC   = PARSE_DELAY_US * CLK_MHZ;
	// interval values are not fixed by the protocol; plain defaults
	localparam int unsigned IO_TIMEOUT_CYC_DEF = 2500;
	localparam int unsigned WDOG_CYC_DEF       = 1000000;
	localparam int unsigned WAKE_CYC_DEF       = 1000;
	localparam int unsigned FIFO_DEPTH_DEF     = 32;

	typedef enum logic [2:0] {
		ST_SLEEP, ST_WAKE_DLY, ST_IDLE, ST_RX_BLK, ST_PARSE, ST_EXEC, ST_TX
	} owa_state_e;

	typedef enum logic [2:0] {
		RESP_NONE, RESP_WAKE, RESP_OK, RESP_EXEC, RESP_COMM
	} owa_resp_e;

	// data enters lsb first, so the register is fed bit 0 first
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = d[i] ^ r[15];
			r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

endpackage

// file: shared/owa_stream_if.sv
// valid/ready byte stream between the engine and its transmit buffer
// assumes both ends on the core clock
interface owa_stream_if #(parameter int unsigned W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
